// >>> verilog/upfc_pkg.sv
// shared constants and types for the ulpi function control ends
package upfc_pkg;

	// clock and core reset timing
	localparam int CLK_MHZ = 50;
	localparam int CORE_RESET_NS = 1000;
	localparam int CORE_RESET_CYC_INT = (CORE_RESET_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] CORE_RESET_CYCLES = 8'(CORE_RESET_CYC_INT);

	// ulpi register addresses
	localparam logic [5:0] ADDR_FC_WR = 6'h04;
	localparam logic [5:0] ADDR_FC_SET = 6'h05;
	localparam logic [5:0] ADDR_FC_CLR = 6'h06;
	localparam logic [5:0] ADDR_IC_WR = 6'h07;
	localparam logic [5:0] ADDR_IC_SET = 6'h08;

	// transmit command prefixes on data[7:6]
	localparam logic [1:0] CMD_REG_WR = 2'h2;
	localparam logic [1:0] CMD_REG_RD = 2'h3;

	// function_control fields
	localparam int FC_LOW_POWER_N = 6;
	localparam int FC_RESET = 5;
	localparam int FC_MODE_LSB = 3;
	localparam int FC_TERM = 2;
	localparam int FC_SPEED_LSB = 0;
	localparam logic [7:0] FC_RESET_VALUE = 8'h41;
	localparam logic [7:0] FC_WRITABLE = 8'h7F;

	// tx_encoding_mode codes
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_NON_DRIVING = 2'h1;
	localparam logic [1:0] MODE_NO_STUFF_NRZI = 2'h2;
	localparam logic [1:0] MODE_NO_SYNC_EOP = 2'h3;

	// transceiver_speed_choice codes
	localparam logic [1:0] SPEED_HS = 2'h0;
	localparam logic [1:0] SPEED_FS = 2'h1;
	localparam logic [1:0] SPEED_LS = 2'h2;
	localparam logic [1:0] SPEED_LS_ON_FS = 2'h3;

	// interface_control alternative serial mode bits
	localparam logic [7:0] IC_ALT_MASK = 8'h03;

	// link controller software registers
	localparam logic [3:0] LREG_ADDR = 4'h0;
	localparam logic [3:0] LREG_WDATA = 4'h1;
	localparam logic [3:0] LREG_READ = 4'h2;
	localparam logic [3:0] LREG_STATUS = 4'h3;
	localparam logic [3:0] LREG_RDATA = 4'h4;
	localparam logic [3:0] LREG_RXCMD = 4'h5;
	localparam logic [3:0] LREG_WAKE = 4'h6;

	// link status bits
	localparam int ST_BUSY = 0;
	localparam int ST_DIR = 1;
	localparam int ST_RST_WAIT = 2;
	localparam int ST_REFUSED = 3;

	typedef enum logic [3:0] {
		PHY_IDLE,
		PHY_W_ACK,
		PHY_W_DATA,
		PHY_W_STP,
		PHY_R_ACK,
		PHY_R_TURN,
		PHY_R_DATA,
		PHY_RST,
		PHY_RX_TURN,
		PHY_RX_DATA,
		PHY_LP
	} upfc_phy_state_t;

	typedef enum logic [3:0] {
		LNK_IDLE,
		LNK_CMD,
		LNK_WDATA,
		LNK_STP,
		LNK_RWAIT,
		LNK_RDATA,
		LNK_RST_WAIT,
		LNK_WAKE
	} upfc_link_state_t;

endpackage

// >>> verilog/upfc_ulpi_if.sv
// ulpi wires between phy end and link end
`timescale 1ns/10ps
interface upfc_ulpi_if;
	logic dir;
	logic nxt;
	logic stp;
	logic [7:0] phy_data;
	logic phy_data_oe;
	logic [7:0] link_data;
	logic link_data_oe;
	logic [7:0] data;

	// bus level resolved from the enables
	assign data = phy_data_oe ? phy_data :
		(link_data_oe ? link_data : 8'h00);

	modport phy (
		output dir,
		output nxt,
		output phy_data,
		output phy_data_oe,
		input stp,
		input data
	);

	modport link (
		input dir,
		input nxt,
		input data,
		output stp,
		output link_data,
		output link_data_oe
	);
endinterface

// >>> verilog/upfc_phy.sv
// phy end: function_control register and the behaviour it drives
`timescale 1ns/10ps
module upfc_phy (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	upfc_ulpi_if.phy ulpi,
	input wire logic [1:0] line_state_in,
	input wire logic dplus_pull_low_en_in,
	input wire logic dminus_pull_low_en_in,
	output logic [7:0] function_control_out,
	output logic low_power_out,
	output logic core_reset_out,
	output logic tx_drive_en_out,
	output logic tx_stuff_nrzi_en_out,
	output logic tx_auto_sync_eop_out,
	output logic hs_xcvr_en_out,
	output logic fs_xcvr_en_out,
	output logic ls_xcvr_en_out,
	output logic fs_preamble_out,
	output logic fs_rx_en_out,
	output logic dp_pullup_out,
	output logic dm_pullup_out,
	output logic hs_term_out
);

	upfc_pkg::upfc_phy_state_t state_r;
	upfc_pkg::upfc_phy_state_t state_nxt;
	logic [7:0] fc_r;
	logic [7:0] fc_nxt;
	logic [5:0] addr_r;
	logic [7:0] wdata_r;
	logic [7:0] rst_cnt_r;
	logic rxcmd_pend_r;
	logic [7:0] data_r;
	logic commit;
	logic rst_done;
	logic lp_exit;
	logic fc_hit;
	logic [1:0] mode;
	logic [1:0] speed;
	logic host_pd;

	// register update for write, set and clear addresses
	function automatic logic [7:0] upfc_reg_update(
		input logic [7:0] cur,
		input logic [5:0] addr,
		input logic [7:0] val
	);
		logic [7:0] res;
		res = cur;
		case (addr)
			upfc_pkg::ADDR_FC_WR: res = val;
			upfc_pkg::ADDR_FC_SET: res = cur | val;
			upfc_pkg::ADDR_FC_CLR: res = cur & ~val;
			default: res = cur;
		endcase
		return res & upfc_pkg::FC_WRITABLE;
	endfunction

	assign commit = (state_r == upfc_pkg::PHY_W_STP) && ulpi.stp;
	assign rst_done = (state_r == upfc_pkg::PHY_RST) && (rst_cnt_r == 8'h00);
	assign lp_exit = (state_r == upfc_pkg::PHY_LP) && ulpi.stp;
	assign fc_hit = (addr_r >= upfc_pkg::ADDR_FC_WR) &&
		(addr_r <= upfc_pkg::ADDR_FC_CLR);
	assign fc_nxt = upfc_reg_update(fc_r, addr_r, wdata_r);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			upfc_pkg::PHY_IDLE: begin
				if (ulpi.data[7:6] == upfc_pkg::CMD_REG_WR) begin
					state_nxt = upfc_pkg::PHY_W_ACK;
				end else if (ulpi.data[7:6] == upfc_pkg::CMD_REG_RD) begin
					state_nxt = upfc_pkg::PHY_R_ACK;
				end else if (rxcmd_pend_r) begin
					state_nxt = upfc_pkg::PHY_RX_TURN;
				end else if (!fc_r[upfc_pkg::FC_LOW_POWER_N]) begin
					state_nxt = upfc_pkg::PHY_LP;
				end
			end
			upfc_pkg::PHY_W_ACK: state_nxt = upfc_pkg::PHY_W_DATA;
			upfc_pkg::PHY_W_DATA: state_nxt = upfc_pkg::PHY_W_STP;
			upfc_pkg::PHY_W_STP: begin
				if (ulpi.stp) begin
					if (fc_nxt[upfc_pkg::FC_RESET]) begin
						state_nxt = upfc_pkg::PHY_RST;
					end else begin
						state_nxt = upfc_pkg::PHY_IDLE;
					end
				end
			end
			upfc_pkg::PHY_R_ACK: state_nxt = upfc_pkg::PHY_R_TURN;
			upfc_pkg::PHY_R_TURN: state_nxt = upfc_pkg::PHY_R_DATA;
			upfc_pkg::PHY_R_DATA: state_nxt = upfc_pkg::PHY_IDLE;
			upfc_pkg::PHY_RST: begin
				if (rst_done) begin
					state_nxt = upfc_pkg::PHY_IDLE;
				end
			end
			upfc_pkg::PHY_RX_TURN: state_nxt = upfc_pkg::PHY_RX_DATA;
			upfc_pkg::PHY_RX_DATA: state_nxt = upfc_pkg::PHY_IDLE;
			upfc_pkg::PHY_LP: begin
				if (ulpi.stp) begin
					state_nxt = upfc_pkg::PHY_IDLE;
				end
			end
			default: state_nxt = upfc_pkg::PHY_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_r <= upfc_pkg::PHY_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// command address and write byte capture
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			addr_r <= 6'h00;
			wdata_r <= 8'h00;
		end else begin
			if (state_r == upfc_pkg::PHY_IDLE) begin
				addr_r <= ulpi.data[5:0];
			end
			if (state_r == upfc_pkg::PHY_W_DATA) begin
				wdata_r <= ulpi.data;
			end
		end
	end

	// function_control storage; the end of core reset clears only the reset bit
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			fc_r <= upfc_pkg::FC_RESET_VALUE;
		end else if (commit) begin
			fc_r <= fc_nxt;
		end else if (rst_done) begin
			fc_r[upfc_pkg::FC_RESET] <= 1'b0;
		end else if (lp_exit) begin
			fc_r[upfc_pkg::FC_LOW_POWER_N] <= 1'b1;
		end
	end

	// core reset length counter
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rst_cnt_r <= 8'h00;
		end else if (state_r != upfc_pkg::PHY_RST) begin
			rst_cnt_r <= upfc_pkg::CORE_RESET_CYCLES - 8'h01;
		end else if (rst_cnt_r != 8'h00) begin
			rst_cnt_r <= rst_cnt_r - 8'h01;
		end
	end

	// rxcmd owed after core reset; set wins over clear
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rxcmd_pend_r <= 1'b0;
		end else if (rst_done) begin
			rxcmd_pend_r <= 1'b1;
		end else if (state_nxt == upfc_pkg::PHY_RX_TURN) begin
			rxcmd_pend_r <= 1'b0;
		end
	end

	// bus byte for the state being entered
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			data_r <= 8'h00;
		end else begin
			case (state_nxt)
				upfc_pkg::PHY_R_DATA: begin
					data_r <= fc_hit ? fc_r : 8'h00;
				end
				upfc_pkg::PHY_RX_DATA: data_r <= {6'h00, line_state_in};
				upfc_pkg::PHY_LP: data_r <= {6'h00, line_state_in};
				default: data_r <= 8'h00;
			endcase
		end
	end

	assign ulpi.dir = (state_r == upfc_pkg::PHY_R_TURN) ||
		(state_r == upfc_pkg::PHY_R_DATA) ||
		(state_r == upfc_pkg::PHY_RST) ||
		(state_r == upfc_pkg::PHY_RX_TURN) ||
		(state_r == upfc_pkg::PHY_RX_DATA) ||
		(state_r == upfc_pkg::PHY_LP);
	assign ulpi.nxt = (state_r == upfc_pkg::PHY_W_ACK) ||
		(state_r == upfc_pkg::PHY_W_DATA) ||
		(state_r == upfc_pkg::PHY_R_ACK);
	assign ulpi.phy_data_oe = (state_r == upfc_pkg::PHY_R_DATA) ||
		(state_r == upfc_pkg::PHY_RX_DATA) ||
		(state_r == upfc_pkg::PHY_LP);
	assign ulpi.phy_data = data_r;

	assign function_control_out = fc_r;
	// transceivers, preamble and hs termination powered down; fs receiver, pullups and tx encoding unaffected
	assign low_power_out = (state_r == upfc_pkg::PHY_LP);
	assign core_reset_out = (state_r == upfc_pkg::PHY_RST);

	assign mode = fc_r[upfc_pkg::FC_MODE_LSB +: 2];
	assign speed = fc_r[upfc_pkg::FC_SPEED_LSB +: 2];
	assign host_pd = dplus_pull_low_en_in & dminus_pull_low_en_in;

	// transmit encoding, transceiver and resistor decode
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			tx_drive_en_out <= 1'b1;
			tx_stuff_nrzi_en_out <= 1'b1;
			tx_auto_sync_eop_out <= 1'b1;
			hs_xcvr_en_out <= 1'b0;
			fs_xcvr_en_out <= 1'b1;
			ls_xcvr_en_out <= 1'b0;
			fs_preamble_out <= 1'b0;
			fs_rx_en_out <= 1'b1;
			dp_pullup_out <= 1'b0;
			dm_pullup_out <= 1'b0;
			hs_term_out <= 1'b0;
		end else begin
			tx_drive_en_out <= (mode != upfc_pkg::MODE_NON_DRIVING);
			tx_stuff_nrzi_en_out <= (mode == upfc_pkg::MODE_NORMAL) ||
				(mode == upfc_pkg::MODE_NO_SYNC_EOP);
			tx_auto_sync_eop_out <= (mode != upfc_pkg::MODE_NO_SYNC_EOP);
			hs_xcvr_en_out <= !low_power_out && (speed == upfc_pkg::SPEED_HS);
			fs_xcvr_en_out <= !low_power_out &&
				((speed == upfc_pkg::SPEED_FS) ||
				(speed == upfc_pkg::SPEED_LS_ON_FS));
			ls_xcvr_en_out <= !low_power_out && (speed == upfc_pkg::SPEED_LS);
			fs_preamble_out <= !low_power_out &&
				(speed == upfc_pkg::SPEED_LS_ON_FS);
			fs_rx_en_out <= 1'b1;
			dp_pullup_out <= !host_pd && fc_r[upfc_pkg::FC_TERM] &&
				(mode != upfc_pkg::MODE_NON_DRIVING) &&
				((speed == upfc_pkg::SPEED_FS) ||
				(speed == upfc_pkg::SPEED_LS_ON_FS));
			dm_pullup_out <= !host_pd && fc_r[upfc_pkg::FC_TERM] &&
				(mode != upfc_pkg::MODE_NON_DRIVING) &&
				(speed == upfc_pkg::SPEED_LS);
			hs_term_out <= !fc_r[upfc_pkg::FC_TERM] && !low_power_out &&
				(mode != upfc_pkg::MODE_NON_DRIVING) &&
				(speed == upfc_pkg::SPEED_HS);
		end
	end

endmodule

// >>> verilog/upfc_link.sv
// link end: ulpi register access driven by a software port
`timescale 1ns/10ps
module upfc_link (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	upfc_ulpi_if.link ulpi,
	input wire logic [3:0] sw_addr_in,
	input wire logic [7:0] sw_wdata_in,
	input wire logic sw_wr_in,
	input wire logic sw_rd_in,
	output logic [7:0] sw_rdata_out
);

	upfc_pkg::upfc_link_state_t state_r;
	logic [5:0] uaddr_r;
	logic [7:0] wdata_r;
	logic req_wr_r;
	logic req_rd_r;
	logic wake_r;
	logic refused_r;
	logic [7:0] rd_result_r;
	logic [7:0] rxcmd_r;
	logic drive_r;
	logic [7:0] data_r;
	logic stp_r;
	logic rst_seen_r;
	logic dir_prev_r;
	logic busy;
	logic legal;
	logic refuse;
	logic wants_reset;

	// write screening before launch
	function automatic logic upfc_write_legal(
		input logic [5:0] a,
		input logic [7:0] d
	);
		logic ok;
		ok = 1'b1;
		// mode 11 only with high speed for the write address
		if ((a == upfc_pkg::ADDR_FC_WR) &&
			(d[upfc_pkg::FC_MODE_LSB +: 2] == upfc_pkg::MODE_NO_SYNC_EOP) &&
			(d[upfc_pkg::FC_SPEED_LSB +: 2] != upfc_pkg::SPEED_HS)) begin
			ok = 1'b0;
		end
		if (((a == upfc_pkg::ADDR_IC_WR) || (a == upfc_pkg::ADDR_IC_SET)) &&
			((d & upfc_pkg::IC_ALT_MASK) == upfc_pkg::IC_ALT_MASK)) begin
			ok = 1'b0;
		end
		return ok;
	endfunction

	assign busy = req_wr_r || req_rd_r || (state_r != upfc_pkg::LNK_IDLE);
	assign legal = upfc_write_legal(uaddr_r, sw_wdata_in);
	assign refuse = (sw_wr_in && (sw_addr_in == upfc_pkg::LREG_WDATA) &&
		(busy || !legal)) ||
		(sw_wr_in && (sw_addr_in == upfc_pkg::LREG_READ) && busy);
	assign wants_reset = wdata_r[upfc_pkg::FC_RESET] &&
		((uaddr_r == upfc_pkg::ADDR_FC_WR) ||
		(uaddr_r == upfc_pkg::ADDR_FC_SET));

	// software requests
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			uaddr_r <= 6'h00;
			wdata_r <= 8'h00;
			req_wr_r <= 1'b0;
			req_rd_r <= 1'b0;
			wake_r <= 1'b0;
		end else begin
			if (sw_wr_in && !busy) begin
				case (sw_addr_in)
					upfc_pkg::LREG_ADDR: uaddr_r <= sw_wdata_in[5:0];
					upfc_pkg::LREG_WDATA: begin
						if (legal) begin
							wdata_r <= sw_wdata_in;
							req_wr_r <= 1'b1;
						end
					end
					upfc_pkg::LREG_READ: req_rd_r <= 1'b1;
					default: ;
				endcase
			end
			if (state_r == upfc_pkg::LNK_STP) begin
				req_wr_r <= 1'b0;
			end
			if (state_r == upfc_pkg::LNK_RDATA) begin
				req_rd_r <= 1'b0;
			end
			if (sw_wr_in && (sw_addr_in == upfc_pkg::LREG_WAKE)) begin
				wake_r <= 1'b1;
			end else if (state_r == upfc_pkg::LNK_WAKE) begin
				wake_r <= 1'b0;
			end
		end
	end

	// refused flag: set wins over the status read clear
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			refused_r <= 1'b0;
		end else if (refuse) begin
			refused_r <= 1'b1;
		end else if (sw_rd_in && (sw_addr_in == upfc_pkg::LREG_STATUS)) begin
			refused_r <= 1'b0;
		end
	end

	// ulpi sequencing
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_r <= upfc_pkg::LNK_IDLE;
			drive_r <= 1'b0;
			data_r <= 8'h00;
			stp_r <= 1'b0;
			rst_seen_r <= 1'b0;
			rd_result_r <= 8'h00;
		end else begin
			case (state_r)
				upfc_pkg::LNK_IDLE: begin
					rst_seen_r <= 1'b0;
					if (wake_r) begin
						stp_r <= 1'b1;
						state_r <= upfc_pkg::LNK_WAKE;
					end else if (!ulpi.dir && (req_wr_r || req_rd_r)) begin
						drive_r <= 1'b1;
						data_r <= {req_wr_r ? upfc_pkg::CMD_REG_WR :
							upfc_pkg::CMD_REG_RD, uaddr_r};
						state_r <= upfc_pkg::LNK_CMD;
					end
				end
				upfc_pkg::LNK_CMD: begin
					if (ulpi.dir) begin
						drive_r <= 1'b0;
						data_r <= 8'h00;
						state_r <= upfc_pkg::LNK_IDLE;
					end else if (ulpi.nxt && req_wr_r) begin
						data_r <= wdata_r;
						state_r <= upfc_pkg::LNK_WDATA;
					end else if (ulpi.nxt) begin
						drive_r <= 1'b0;
						data_r <= 8'h00;
						state_r <= upfc_pkg::LNK_RWAIT;
					end
				end
				upfc_pkg::LNK_WDATA: begin
					if (ulpi.nxt) begin
						stp_r <= 1'b1;
						data_r <= 8'h00;
						state_r <= upfc_pkg::LNK_STP;
					end
				end
				upfc_pkg::LNK_STP: begin
					stp_r <= 1'b0;
					drive_r <= 1'b0;
					if (wants_reset) begin
						state_r <= upfc_pkg::LNK_RST_WAIT;
					end else begin
						state_r <= upfc_pkg::LNK_IDLE;
					end
				end
				upfc_pkg::LNK_RWAIT: begin
					if (ulpi.dir) begin
						state_r <= upfc_pkg::LNK_RDATA;
					end
				end
				upfc_pkg::LNK_RDATA: begin
					rd_result_r <= ulpi.data;
					state_r <= upfc_pkg::LNK_IDLE;
				end
				upfc_pkg::LNK_RST_WAIT: begin
					if (ulpi.dir) begin
						rst_seen_r <= 1'b1;
					end else if (rst_seen_r) begin
						state_r <= upfc_pkg::LNK_IDLE;
					end
				end
				upfc_pkg::LNK_WAKE: begin
					if (!ulpi.dir) begin
						stp_r <= 1'b0;
						state_r <= upfc_pkg::LNK_IDLE;
					end
				end
				default: state_r <= upfc_pkg::LNK_IDLE;
			endcase
		end
	end

	// turnaround-qualified rxcmd capture
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			dir_prev_r <= 1'b0;
			rxcmd_r <= 8'h00;
		end else begin
			dir_prev_r <= ulpi.dir;
			if (ulpi.dir && dir_prev_r && !ulpi.nxt &&
				(state_r != upfc_pkg::LNK_RWAIT) &&
				(state_r != upfc_pkg::LNK_RDATA)) begin
				rxcmd_r <= ulpi.data;
			end
		end
	end

	// software read data, valid in the cycle after the strobe
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			sw_rdata_out <= 8'h00;
		end else if (sw_rd_in) begin
			case (sw_addr_in)
				upfc_pkg::LREG_ADDR: sw_rdata_out <= {2'h0, uaddr_r};
				upfc_pkg::LREG_WDATA: sw_rdata_out <= wdata_r;
				upfc_pkg::LREG_STATUS: begin
					sw_rdata_out <= {4'h0, refused_r,
						state_r == upfc_pkg::LNK_RST_WAIT, ulpi.dir, busy};
				end
				upfc_pkg::LREG_RDATA: sw_rdata_out <= rd_result_r;
				upfc_pkg::LREG_RXCMD: sw_rdata_out <= rxcmd_r;
				default: sw_rdata_out <= 8'h00;
			endcase
		end else begin
			sw_rdata_out <= 8'h00;
		end
	end

	// oe drops at once when the phy takes the bus
	assign ulpi.link_data_oe = drive_r && !ulpi.dir;
	assign ulpi.link_data = data_r;
	assign ulpi.stp = stp_r;

endmodule

// >>> bench/upfc_checker.sv
// assertions on the ulpi wires between phy end and link end
`timescale 1ns/10ps
module upfc_checker (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic dir,
	input wire logic nxt,
	input wire logic stp,
	input wire logic [7:0] phy_data,
	input wire logic phy_data_oe,
	input wire logic [7:0] link_data,
	input wire logic link_data_oe,
	input wire logic [7:0] data
);
	logic [7:0] cmd_r;
	logic [7:0] byte_r;
	logic acc_r;
	logic commit;
	logic rst_go;
	logic lp_go;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	// last two bytes the phy accepted
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cmd_r <= 8'h00;
			byte_r <= 8'h00;
			acc_r <= 1'b0;
		end else begin
			acc_r <= nxt && link_data_oe;
			if (nxt && link_data_oe) begin
				cmd_r <= byte_r;
				byte_r <= data;
			end
		end
	end
	assign commit = stp && !dir && acc_r && cmd_r[7:6] == upfc_pkg::CMD_REG_WR;
	assign rst_go = commit && byte_r[5] && (cmd_r[5:0] == upfc_pkg::ADDR_FC_WR
		|| cmd_r[5:0] == upfc_pkg::ADDR_FC_SET);
	assign lp_go = commit && ((cmd_r[5:0] == upfc_pkg::ADDR_FC_WR
		&& !byte_r[6] && !byte_r[5])
		|| (cmd_r[5:0] == upfc_pkg::ADDR_FC_CLR && byte_r[6]));
	a_link_yields: assert property (link_data_oe |-> !dir)
		else $error("link drives while phy owns bus");
	a_phy_owns: assert property (phy_data_oe |-> dir && !link_data_oe)
		else $error("phy drives without dir");
	a_write_ack: assert property ($rose(link_data_oe)
		&& link_data[7:6] == upfc_pkg::CMD_REG_WR
		|=> nxt ##1 nxt ##1 (stp && !nxt))
		else $error("register write handshake wrong");
	a_read_turn: assert property ($rose(link_data_oe)
		&& link_data[7:6] == upfc_pkg::CMD_REG_RD
		|=> nxt ##1 (dir && !phy_data_oe) ##1 (dir && phy_data_oe) ##1 !dir)
		else $error("register read turnaround wrong");
	a_bit7_zero: assert property (phy_data_oe |-> !phy_data[7])
		else $error("phy byte has bit 7 set");
	a_reset_hold: assert property (rst_go |=> dir[*8] ##42 dir ##1 !dir)
		else $error("core reset dir window wrong");
	a_reset_rxcmd: assert property (rst_go |=> ##50 !dir
		##1 (dir && !phy_data_oe) ##1 (dir && phy_data_oe) ##1 !dir)
		else $error("no rxcmd after core reset");
	a_lp_entry: assert property (lp_go |=> !dir ##1 (dir && phy_data_oe))
		else $error("low power not entered");
	a_lp_exit: assert property (dir && phy_data_oe && stp |=> !dir)
		else $error("stp did not end low power");
	a_stp_single: assert property (stp && !dir |=> !stp)
		else $error("stp held after dir low");
	c_reset: cover property (rst_go);
	c_lp: cover property (lp_go);
	c_exit: cover property (dir && phy_data_oe && stp);
endmodule

// >>> bench/upfc_tb.sv
// self-checking bench joining the phy and link ends
`timescale 1ns/10ps
module upfc_tb;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic [1:0] line_state = 2'h0;
	logic dp_pd = 1'b0;
	logic dm_pd = 1'b0;
	logic [3:0] sw_addr = 4'h0;
	logic [7:0] sw_wdata = 8'h00;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic [7:0] sw_rdata;
	logic [7:0] fc;
	logic low_power;
	logic core_reset;
	wire logic [10:0] dec;
	int err_count = 0;
	int n_tests = 0;
	always #10 clk_sys_in = ~clk_sys_in;
	upfc_ulpi_if upfc_ulpi_if_inst ();
	upfc_phy upfc_phy_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.ulpi(upfc_ulpi_if_inst), .line_state_in(line_state),
		.dplus_pull_low_en_in(dp_pd), .dminus_pull_low_en_in(dm_pd),
		.function_control_out(fc), .low_power_out(low_power),
		.core_reset_out(core_reset), .tx_drive_en_out(dec[10]),
		.tx_stuff_nrzi_en_out(dec[9]), .tx_auto_sync_eop_out(dec[8]),
		.hs_xcvr_en_out(dec[7]), .fs_xcvr_en_out(dec[6]),
		.ls_xcvr_en_out(dec[5]), .fs_preamble_out(dec[4]),
		.fs_rx_en_out(dec[3]), .dp_pullup_out(dec[2]),
		.dm_pullup_out(dec[1]), .hs_term_out(dec[0]));
	upfc_link upfc_link_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.ulpi(upfc_ulpi_if_inst), .sw_addr_in(sw_addr),
		.sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd),
		.sw_rdata_out(sw_rdata));
	upfc_checker upfc_checker_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.dir(upfc_ulpi_if_inst.dir), .nxt(upfc_ulpi_if_inst.nxt),
		.stp(upfc_ulpi_if_inst.stp), .phy_data(upfc_ulpi_if_inst.phy_data),
		.phy_data_oe(upfc_ulpi_if_inst.phy_data_oe),
		.link_data(upfc_ulpi_if_inst.link_data),
		.link_data_oe(upfc_ulpi_if_inst.link_data_oe),
		.data(upfc_ulpi_if_inst.data));
	task automatic close_out();
		$display("errors %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input logic [10:0] got, input logic [10:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clk_sys_in);
		sw_wr <= 1'b0;
	endtask
	task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys_in);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk_sys_in);
		sw_rd <= 1'b0;
		@(negedge clk_sys_in);
		d = sw_rdata;
	endtask
	// polls busy, reset wait and dir until all low
	task automatic wait_idle();
		logic [7:0] s;
		for (int i = 0; i < 200; i++) begin
			sw_read(upfc_pkg::LREG_STATUS, s);
			if (s[2:0] === 3'h0) return;
		end
		err_count++;
		close_out();
	endtask
	task automatic ulpi_write(input logic [5:0] a, input logic [7:0] d);
		sw_write(upfc_pkg::LREG_ADDR, {2'h0, a});
		sw_write(upfc_pkg::LREG_WDATA, d);
	endtask
	task automatic ulpi_read(input logic [5:0] a, output logic [7:0] d);
		sw_write(upfc_pkg::LREG_ADDR, {2'h0, a});
		sw_write(upfc_pkg::LREG_READ, 8'h00);
		wait_idle();
		sw_read(upfc_pkg::LREG_RDATA, d);
	endtask
	function automatic logic [7:0] fc_apply(logic [7:0] cur, logic [5:0] a,
		logic [7:0] v);
		if (a == upfc_pkg::ADDR_FC_SET) return (cur | v) & 8'h7f;
		if (a == upfc_pkg::ADDR_FC_CLR) return cur & ~v;
		return v & 8'h7f;
	endfunction
	function automatic logic [10:0] dec_exp(logic [7:0] f, logic lp,
		logic host);
		logic [1:0] m;
		logic [1:0] s;
		logic on;
		m = f[4:3];
		s = f[1:0];
		on = f[2] && !host && m != 2'h1;
		return {m != 2'h1, m == 2'h0 || m == 2'h3, m != 2'h3,
			!lp && s == 2'h0, !lp && s[0], !lp && s == 2'h2,
			!lp && s == 2'h3, 1'b1, on && s[0], on && s == 2'h2,
			!f[2] && !lp && m != 2'h1 && s == 2'h0};
	endfunction
	initial begin
		repeat (90000) @(posedge clk_sys_in);
		err_count++;
		close_out();
	end
	initial begin
		logic [7:0] d;
		logic [7:0] r;
		logic [5:0] a;
		logic [7:0] fc_m;
		void'($urandom(74431));
		fc_m = 8'h41;
		repeat (3) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(negedge clk_sys_in);
		check({3'h0, fc}, 11'h041);
		check(dec, dec_exp(8'h41, 1'b0, 1'b0));
		// first sixteen sweep every mode and speed
		for (int i = 0; i < 40; i++) begin
			@(posedge clk_sys_in);
			dp_pd <= 1'($urandom);
			dm_pd <= 1'($urandom);
			d = 8'($urandom);
			a = upfc_pkg::ADDR_FC_WR + 6'($urandom_range(2));
			if (i < 16) begin
				a = upfc_pkg::ADDR_FC_WR;
				d[4:0] = {i[3:2], d[2], i[1:0]};
			end
			d[5] = 1'b0;
			d[6] = (a != upfc_pkg::ADDR_FC_CLR);
			ulpi_write(a, d);
			if (a == upfc_pkg::ADDR_FC_WR && d[4:3] == 2'h3 &&
				d[1:0] != 2'h0) begin
				sw_read(upfc_pkg::LREG_STATUS, r);
				check({10'h0, r[3]}, 11'h001);
			end else begin
				fc_m = fc_apply(fc_m, a, d);
			end
			wait_idle();
			ulpi_read(upfc_pkg::ADDR_FC_WR + 6'($urandom_range(2)), r);
			check({3'h0, r}, {3'h0, fc_m});
			check(dec, dec_exp(fc_m, 1'b0, dp_pd && dm_pd));
		end
		// both alternative serial modes at once are refused
		ulpi_write(upfc_pkg::ADDR_IC_WR, 8'h03);
		sw_read(upfc_pkg::LREG_STATUS, r);
		check({10'h0, r[3]}, 11'h001);
		ulpi_write(upfc_pkg::ADDR_IC_SET, 8'h01);
		sw_read(upfc_pkg::LREG_STATUS, r);
		check({10'h0, r[3]}, 11'h000);
		wait_idle();
		check({3'h0, fc}, {3'h0, fc_m});
		@(posedge clk_sys_in);
		line_state <= 2'($urandom);
		ulpi_write(upfc_pkg::ADDR_FC_SET, 8'h20);
		repeat (20) @(negedge clk_sys_in);
		check({9'h0, core_reset, upfc_ulpi_if_inst.dir}, 11'h003);
		wait_idle();
		repeat (8) @(posedge clk_sys_in);
		sw_read(upfc_pkg::LREG_RXCMD, r);
		check({3'h0, r}, {9'h0, line_state});
		check({2'h0, core_reset, fc}, {3'h0, fc_m});
		for (int k = 0; k < 2; k++) begin
			d = (k == 0) ? 8'h40 : 8'h09;
			a = (k == 0) ? upfc_pkg::ADDR_FC_CLR : upfc_pkg::ADDR_FC_WR;
			ulpi_write(a, d);
			fc_m = fc_apply(fc_m, a, d);
			repeat (10) @(negedge clk_sys_in);
			check({10'h0, low_power}, 11'h001);
			check(dec, dec_exp(fc_m, 1'b1, dp_pd && dm_pd));
			sw_write(upfc_pkg::LREG_WAKE, 8'h00);
			wait_idle();
			fc_m[6] = 1'b1;
			check({2'h0, low_power, fc}, {3'h0, fc_m});
		end
		sw_write(upfc_pkg::LREG_WAKE, 8'h00);
		wait_idle();
		check({2'h0, low_power, fc}, {3'h0, fc_m});
		close_out();
	end
endmodule
